/* verilog/pahc_params.svh */
// register offsets, field positions and reset values for the paging alpha header checker
// assumes a 32-bit apb slave with byte addresses and one word per register
`ifndef PAHC_PARAMS_SVH
`define PAHC_PARAMS_SVH
`define PAHC_OFF_CTRL 12'h000
`define PAHC_OFF_STATUS 12'h004
`define PAHC_OFF_MISS 12'h008
`define PAHC_OFF_COUNT 12'h00c
`define PAHC_OFF_MAIL_LEN 12'h010
`define PAHC_OFF_MAIL_BASE 12'h040
`define PAHC_RST_LIMIT 6'h3f
`define PAHC_HDR_CONT 10
`define PAHC_HDR_FRAG_LO 11
`define PAHC_HDR_NUM_LO 13
`define PAHC_HDR_U 19
`define PAHC_HDR_V 20
`define PAHC_FRAG_INIT 2'h3
`define PAHC_W2_RETR 0
`define PAHC_W2_MAIL 1
`define PAHC_W2_SIG_LO 2
`endif

/* verilog/pahc_pkg.sv */
// types shared by the paging alpha header checker and its fifo
// assumes the params header supplies all offsets and field positions
package pahc_pkg;
    typedef enum logic [1:0] {ST_HDR, ST_SIG, ST_BODY} pahc_st_t;
    typedef enum logic [1:0] {MODE_UNSUP, MODE_RSVD, MODE_DEFAULT, MODE_ALT} pahc_mode_t;
    typedef struct packed {
        logic [20:0] info;
        logic [7:0] addr;
        logic first;
        logic last;
    } pahc_cw_t;
    typedef struct packed {
        logic [20:0] info;
        logic [7:0] addr;
        logic [5:0] num;
        logic first;
        logic last;
    } pahc_msg_t;
endpackage : pahc_pkg

/* verilog/pahc_checker.sv */
// paging alpha header checker: header decode, numbering check, signature, mail store, output fifo
// assumes code words arrive in order with first/last marking each fragment; apb master per amba
// Function
// - rollover limit comes from a register
// - out of order numbering flags missed message
// - sequence checked only when retrieval flag set
// - retrieval zero ignores and leaves tracking
// - report range of missing message numbers
// - address plus number associate fragments
// - mail drop overwrites dedicated store
// - signature is complemented 7-bit character sum
// - sum characters after signature field
// - fragment control pair only after first
// - fragment control pair defaults to two
// - fragment control tracks symbolic character position
// - decode pair: unsupported, reserved, default, alternate
// - first fragment assumes default character mode
// - pair zero allows characters split across fragments
`timescale 1ns/10ps
`include "pahc_params.svh"

module pahc_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } pahc_fifo_state_t;
    pahc_fifo_state_t st_ff;
    pahc_fifo_state_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_ff.cnt != '0);
    assign out_data = st_ff.mem[st_ff.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : pahc_fifo

module pahc_checker #(
    parameter int ADDR_N = 8,
    parameter int MAIL_DEPTH = 16,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cw_valid,
    output logic cw_ready,
    input wire pahc_pkg::pahc_cw_t cw,
    output logic msg_valid,
    input wire logic msg_ready,
    output pahc_pkg::pahc_msg_t msg,
    output logic missed,
    output logic [5:0] miss_first,
    output logic [5:0] miss_last,
    output logic sig_ok,
    output logic sig_err,
    output logic frag_orphan,
    output pahc_pkg::pahc_mode_t char_mode,
    output logic split_ok
);
    localparam int AW = (ADDR_N > 1) ? $clog2(ADDR_N) : 1;
    localparam int MW = $clog2(MAIL_DEPTH + 1);
    typedef struct packed {
        pahc_pkg::pahc_st_t st;
        logic open;
        logic skip;
        logic mail;
        logic final_frag;
        logic [7:0] addr;
        logic [5:0] num;
        logic [6:0] sum;
        logic [6:0] sig;
        pahc_pkg::pahc_mode_t mode;
        logic split_ok;
        logic [ADDR_N-1:0] seen;
        logic [ADDR_N-1:0][5:0] last_num;
        logic [MAIL_DEPTH-1:0][20:0] mail_mem;
        logic [MW-1:0] mail_len;
        logic [5:0] limit;
        logic [15:0] missed_cnt;
        logic [15:0] sigerr_cnt;
        logic missed;
        logic sig_ok;
        logic sig_err;
        logic orphan;
        logic [5:0] miss_first;
        logic [5:0] miss_last;
        logic [31:0] prdata;
        logic pslverr;
    } pahc_state_t;

    pahc_state_t st_ff;
    pahc_state_t nxt_st;
    logic take;
    logic push;
    logic fifo_ready;
    pahc_pkg::pahc_msg_t push_msg;

    // wrap after the configured limit, not after 63
    function automatic logic [5:0] pahc_next_num(input logic [5:0] n, input logic [5:0] lim);
        pahc_next_num = (n >= lim) ? 6'h00 : n + 6'h01;
    endfunction : pahc_next_num

    function automatic logic [5:0] pahc_prev_num(input logic [5:0] n, input logic [5:0] lim);
        pahc_prev_num = (n == 6'h00) ? lim : n - 6'h01;
    endfunction : pahc_prev_num

    // three 7-bit characters per word, low bits first
    function automatic logic [6:0] pahc_word_sum(input logic [20:0] w);
        pahc_word_sum = w[6:0] + w[13:7] + w[20:14];
    endfunction : pahc_word_sum

    // stall the whole word path on a full fifo so nothing is dropped
    assign cw_ready = fifo_ready;
    assign take = cw_valid && fifo_ready;
    assign pready = 1'b1;
    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.pslverr;
    assign missed = st_ff.missed;
    assign miss_first = st_ff.miss_first;
    assign miss_last = st_ff.miss_last;
    assign sig_ok = st_ff.sig_ok;
    assign sig_err = st_ff.sig_err;
    assign frag_orphan = st_ff.orphan;
    assign char_mode = st_ff.mode;
    assign split_ok = st_ff.split_ok;

    always_comb begin
        logic [5:0] hnum;
        logic [5:0] expect_num;
        logic [AW-1:0] idx;
        logic apb_wr;
        logic apb_rd;
        logic cnt_clr;
        logic miss_inc;
        logic err_inc;
        logic [11:0] mail_off;
        hnum = cw.info[`PAHC_HDR_NUM_LO +: 6];
        idx = st_ff.addr[AW-1:0];
        expect_num = pahc_next_num(st_ff.last_num[idx], st_ff.limit);
        apb_wr = psel && penable && pwrite;
        apb_rd = psel && !penable && !pwrite;
        cnt_clr = apb_wr && (paddr == `PAHC_OFF_COUNT);
        miss_inc = 1'b0;
        err_inc = 1'b0;
        mail_off = paddr - `PAHC_OFF_MAIL_BASE;
        push = 1'b0;
        push_msg = '0;
        nxt_st = st_ff;
        nxt_st.missed = 1'b0;
        nxt_st.sig_ok = 1'b0;
        nxt_st.sig_err = 1'b0;
        nxt_st.orphan = 1'b0;
        if (take) begin
            unique case (st_ff.st)
                pahc_pkg::ST_HDR: begin
                    if (cw.first) begin
                        nxt_st.final_frag = !cw.info[`PAHC_HDR_CONT];
                        if (cw.info[`PAHC_HDR_FRAG_LO +: 2] == `PAHC_FRAG_INIT) begin
                            nxt_st.open = 1'b1;
                            nxt_st.skip = 1'b0;
                            nxt_st.addr = cw.addr;
                            nxt_st.num = hnum;
                            nxt_st.sum = 7'h00;
                            nxt_st.mode = pahc_pkg::MODE_DEFAULT;
                            nxt_st.split_ok = 1'b0;
                            nxt_st.st = cw.last ? pahc_pkg::ST_HDR : pahc_pkg::ST_SIG;
                        end else if (st_ff.open && cw.addr == st_ff.addr && hnum == st_ff.num) begin
                            nxt_st.skip = 1'b0;
                            unique case ({cw.info[`PAHC_HDR_U], cw.info[`PAHC_HDR_V]})
                                2'h0: nxt_st.mode = pahc_pkg::MODE_UNSUP;
                                2'h1: nxt_st.mode = pahc_pkg::MODE_RSVD;
                                2'h2: nxt_st.mode = pahc_pkg::MODE_DEFAULT;
                                2'h3: nxt_st.mode = pahc_pkg::MODE_ALT;
                            endcase
                            nxt_st.split_ok = !cw.info[`PAHC_HDR_U] && !cw.info[`PAHC_HDR_V];
                            nxt_st.st = cw.last ? pahc_pkg::ST_HDR : pahc_pkg::ST_BODY;
                        end else begin
                            nxt_st.skip = 1'b1;
                            nxt_st.orphan = 1'b1;
                            nxt_st.st = cw.last ? pahc_pkg::ST_HDR : pahc_pkg::ST_BODY;
                        end
                    end
                end
                pahc_pkg::ST_SIG: begin
                    nxt_st.mail = cw.info[`PAHC_W2_MAIL];
                    if (cw.info[`PAHC_W2_MAIL]) begin
                        nxt_st.mail_len = '0;
                    end
                    if (cw.info[`PAHC_W2_RETR]) begin
                        nxt_st.seen[idx] = 1'b1;
                        nxt_st.last_num[idx] = st_ff.num;
                        if (st_ff.seen[idx] && st_ff.num != expect_num) begin
                            nxt_st.missed = 1'b1;
                            miss_inc = 1'b1;
                            nxt_st.miss_first = expect_num;
                            nxt_st.miss_last = pahc_prev_num(st_ff.num, st_ff.limit);
                        end
                    end
                    nxt_st.sum = 7'h00;
                    nxt_st.sig = cw.info[`PAHC_W2_SIG_LO +: 7];
                    nxt_st.st = pahc_pkg::ST_BODY;
                    if (cw.last) begin
                        nxt_st.st = pahc_pkg::ST_HDR;
                    end
                end
                pahc_pkg::ST_BODY: begin
                    if (!st_ff.skip) begin
                        nxt_st.sum = st_ff.sum + pahc_word_sum(cw.info);
                        if (st_ff.mail) begin
                            if (st_ff.mail_len < MW'(MAIL_DEPTH)) begin
                                nxt_st.mail_mem[st_ff.mail_len] = cw.info;
                                nxt_st.mail_len = st_ff.mail_len + 1'b1;
                            end
                        end else begin
                            push = 1'b1;
                        end
                    end
                    if (cw.last) begin
                        nxt_st.st = pahc_pkg::ST_HDR;
                    end
                end
                default: nxt_st.st = pahc_pkg::ST_HDR;
            endcase
            push_msg.info = cw.info;
            push_msg.addr = st_ff.addr;
            push_msg.num = st_ff.num;
            push_msg.first = (st_ff.sum == 7'h00);
            push_msg.last = cw.last && st_ff.final_frag;
        end
        // checked only on the last word of the closing fragment
        if (take && cw.last && st_ff.st != pahc_pkg::ST_HDR && !st_ff.skip && st_ff.final_frag) begin
            if (~nxt_st.sum == st_ff.sig) begin
                nxt_st.sig_ok = 1'b1;
            end else begin
                nxt_st.sig_err = 1'b1;
                err_inc = 1'b1;
            end
            nxt_st.open = 1'b0;
        end
        if (take && cw.last && cw.first && st_ff.st == pahc_pkg::ST_HDR && !cw.info[`PAHC_HDR_CONT]) begin
            nxt_st.open = 1'b0;
        end
        // an event in the clearing cycle survives as a count of one
        nxt_st.missed_cnt = (cnt_clr ? 16'h0000 : st_ff.missed_cnt) + {15'h0000, miss_inc};
        nxt_st.sigerr_cnt = (cnt_clr ? 16'h0000 : st_ff.sigerr_cnt) + {15'h0000, err_inc};
        if (apb_wr && paddr == `PAHC_OFF_CTRL) begin
            nxt_st.limit = pwdata[5:0];
        end
        if (psel && !penable) begin
            nxt_st.prdata = 32'h0000_0000;
            nxt_st.pslverr = 1'b0;
            if (paddr == `PAHC_OFF_CTRL) begin
                nxt_st.prdata = {26'h0000000, st_ff.limit};
            end else if (paddr == `PAHC_OFF_STATUS) begin
                nxt_st.prdata = {26'h0000000, st_ff.mail, st_ff.split_ok, st_ff.mode, st_ff.skip, st_ff.open};
            end else if (paddr == `PAHC_OFF_MISS) begin
                nxt_st.prdata = {18'h00000, st_ff.miss_last, 2'h0, st_ff.miss_first};
            end else if (paddr == `PAHC_OFF_COUNT) begin
                nxt_st.prdata = {st_ff.sigerr_cnt, st_ff.missed_cnt};
            end else if (paddr == `PAHC_OFF_MAIL_LEN) begin
                nxt_st.prdata = 32'(st_ff.mail_len);
            end else if (paddr >= `PAHC_OFF_MAIL_BASE && mail_off[1:0] == 2'h0
                         && mail_off[11:2] < 10'(MAIL_DEPTH)) begin
                nxt_st.prdata = {11'h000, st_ff.mail_mem[mail_off[11:2]]};
            end else begin
                nxt_st.pslverr = 1'b1;
            end
            if (pwrite) begin
                nxt_st.prdata = 32'h0000_0000;
            end
        end
        // error stands only in its own access phase
        if (!psel || penable) begin
            nxt_st.pslverr = 1'b0;
        end
        if (!apb_rd && !(psel && penable)) begin
            nxt_st.prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.st <= pahc_pkg::ST_HDR;
            st_ff.mode <= pahc_pkg::MODE_DEFAULT;
            st_ff.limit <= `PAHC_RST_LIMIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    pahc_fifo #(
        .WIDTH($bits(pahc_pkg::pahc_msg_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_msg),
        .out_valid(msg_valid),
        .out_ready(msg_ready),
        .out_data(msg)
    );
endmodule : pahc_checker

/* testbench/pahc_props.sv */
// assertions on the header checker top ports
// assumes it is bound to pahc_checker and sees its ports only
`timescale 1ns/10ps
module pahc_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic cw_valid,
    input wire logic cw_ready,
    input wire pahc_pkg::pahc_cw_t cw,
    input wire logic missed,
    input wire logic sig_ok,
    input wire logic sig_err,
    input wire logic frag_orphan,
    input wire pahc_pkg::pahc_mode_t char_mode,
    input wire logic split_ok
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        cw_valid && cw_ready;
    endsequence
    sequence s_init_hdr;
        s_take ##0 (cw.first && cw.info[12:11] == 2'b11);
    endsequence
    sequence s_cont_hdr;
        s_take ##0 (cw.first && cw.info[12:11] != 2'b11);
    endsequence
    a_missed_after_word: assert property (missed |-> $past(cw_valid && cw_ready && !cw.first))
        else $error("missed pulse without a taken word");
    a_sig_after_last: assert property ((sig_ok || sig_err) |-> $past(cw_valid && cw_ready && cw.last))
        else $error("signature verdict without a last word");
    a_sig_one_verdict: assert property (!(sig_ok && sig_err))
        else $error("signature ok and error together");
    a_init_mode: assert property (s_init_hdr |=> char_mode == pahc_pkg::MODE_DEFAULT)
        else $error("initial fragment not in default mode");
    a_uv_decode: assert property (s_cont_hdr |=> frag_orphan ||
        char_mode == pahc_pkg::pahc_mode_t'({$past(cw.info[19]), $past(cw.info[20])}))
        else $error("fragment control pair decoded wrongly");
    a_split_pair: assert property (s_cont_hdr |=> frag_orphan ||
        split_ok == ($past(cw.info[20:19]) == 2'b00))
        else $error("split flag does not follow the pair");
    a_orphan_cause: assert property (frag_orphan |-> $past(cw_valid && cw_ready))
        else $error("orphan pulse without a taken word");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
endmodule : pahc_props

bind pahc_checker pahc_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pslverr(pslverr),
    .cw_valid(cw_valid), .cw_ready(cw_ready), .cw(cw), .missed(missed), .sig_ok(sig_ok), .sig_err(sig_err),
    .frag_orphan(frag_orphan), .char_mode(char_mode), .split_ok(split_ok));

/* testbench/pahc_partner.sv */
// code word source and host consumer facing the header checker
// assumes put is called just after a rising edge
`timescale 1ns/10ps
module pahc_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    output logic cw_valid,
    input wire logic cw_ready,
    output pahc_pkg::pahc_cw_t cw,
    input wire logic msg_valid,
    output logic msg_ready,
    input wire pahc_pkg::pahc_msg_t msg
);
    logic [28:0] got[$];
    logic [3:0] tick;
    initial begin
        cw_valid = 1'b0;
        cw = '0;
        msg_ready = 1'b0;
        tick = 4'h0;
    end
    // host is never always ready; under stall it nearly stops
    always @(posedge clk) begin
        tick <= tick + 4'h1;
        msg_ready <= !rst && (stall ? tick == 4'h0 : tick[1:0] != 2'h3);
        if (msg_valid && msg_ready) got.push_back({msg.addr, msg.info});
    end
    task automatic put(input pahc_pkg::pahc_cw_t w);
        logic rdy;
        cw_valid <= 1'b1;
        cw <= w;
        do begin
            @(posedge clk);
            rdy = cw_ready;
        end while (!rdy);
    endtask : put
    // released word lines show the inverse, not the old value
    task automatic idle();
        cw_valid <= 1'b0;
        cw <= ~cw;
        @(posedge clk);
    endtask : idle
endmodule : pahc_partner

/* testbench/tb_pahc_checker.sv */
// self-checking bench for the paging alpha header checker
// assumes the params header offsets and the partner model
`timescale 1ns/10ps
`include "pahc_params.svh"
module tb_pahc_checker;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, stall, er;
    logic saw_full = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cw_valid, cw_ready, msg_valid, msg_ready, missed, sig_ok, sig_err, frag_orphan, split_ok;
    logic [5:0] miss_first, miss_last;
    pahc_pkg::pahc_cw_t cw;
    pahc_pkg::pahc_msg_t msg;
    pahc_pkg::pahc_mode_t char_mode;
    int num_errors = 0, n_tests = 0, cyc = 0, n_miss = 0, n_ok = 0, n_err = 0, n_orph = 0;
    logic [28:0] exp_q[$];
    pahc_checker dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cw_valid(cw_valid),
        .cw_ready(cw_ready), .cw(cw), .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg), .missed(missed),
        .miss_first(miss_first), .miss_last(miss_last), .sig_ok(sig_ok), .sig_err(sig_err),
        .frag_orphan(frag_orphan), .char_mode(char_mode), .split_ok(split_ok));
    pahc_partner u_part (.clk(clk), .rst(rst), .stall(stall), .cw_valid(cw_valid), .cw_ready(cw_ready), .cw(cw),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (missed === 1'b1) n_miss <= n_miss + 1;
        if (sig_ok === 1'b1) n_ok <= n_ok + 1;
        if (sig_err === 1'b1) n_err <= n_err + 1;
        if (frag_orphan === 1'b1) n_orph <= n_orph + 1;
        if (cw_valid && cw_ready !== 1'b1) saw_full <= 1'b1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic r;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            r = pready;
            rd = prdata;
            er = pslverr;
        end while (r !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    function automatic logic [6:0] csum(input logic [20:0] b, input int nb);
        logic [6:0] s;
        logic [20:0] w;
        s = 7'h00;
        for (int k = 0; k < nb; k++) begin
            w = b + 21'(k);
            s = s + w[6:0] + w[13:7] + w[20:14];
        end
        return s;
    endfunction : csum
    task automatic body(input logic [7:0] a, input logic [20:0] b, input int nb, input logic keep);
        pahc_pkg::pahc_cw_t w;
        for (int k = 0; k < nb; k++) begin
            w = '{info: b + 21'(k), addr: a, first: 1'b0, last: k == nb - 1};
            u_part.put(w);
            if (keep) exp_q.push_back({a, w.info});
        end
    endtask : body
    task automatic head(input logic [7:0] a, input logic [5:0] n, input logic c, input logic [1:0] f,
        input logic [1:0] uv);
        pahc_pkg::pahc_cw_t w;
        w = '{info: {uv[0], uv[1], n, f, c, 10'h000}, addr: a, first: 1'b1, last: 1'b0};
        u_part.put(w);
    endtask : head
    task automatic msg1(input logic [7:0] a, input logic [5:0] n, input logic r, input logic m, input logic c,
        input logic [6:0] s, input logic [20:0] b, input int nb);
        head(a, n, c, 2'b11, 2'b00);
        u_part.put('{info: {12'h000, s, m, r}, addr: a, first: 1'b0, last: 1'b0});
        body(a, b, nb, !m);
    endtask : msg1
    task automatic settle();
        u_part.idle();
        repeat (3) @(posedge clk);
    endtask : settle
    initial begin
        int ta[7] = '{1, 1, 2, 1, 1, 1, 1};
        int tn[7] = '{0, 1, 2, 3, 0, 2, 2};
        int tr[7] = '{1, 1, 1, 1, 1, 0, 1};
        int em[7] = '{0, 0, 0, 1, 1, 1, 2};
        logic [6:0] st;
        logic [1:0] uv;
        int ok0;
        {rst, psel, penable, pwrite, paddr, pwdata, stall} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `PAHC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0000003f);
        apb(1'b1, `PAHC_OFF_CTRL, 32'h00000003);
        apb(1'b0, `PAHC_OFF_CTRL, 32'h0);
        chk(rd, 32'h00000003);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], er}, 32'h00000001);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            msg1(8'(ta[i]), 6'(tn[i]), tr[i][0], 1'b0, 1'b0, ~csum(21'(i * 37 + 5), 1), 21'(i * 37 + 5), 1);
            settle();
            chk(n_miss, em[i]);
            if (i == 3) chk({miss_last, miss_first}, 32'h082);
        end
        chk({miss_last, miss_first}, 32'h041);
        chk(n_ok, 7);
        $display("test numbering done");
        stall <= 1'b1;
        st = csum(21'h000abc, 2);
        for (int j = 0; j < 4; j++) st = st + csum(21'h001000 + 21'(j * 16), 2);
        ok0 = n_ok;
        msg1(8'h03, 6'h07, 1'b0, 1'b0, 1'b1, ~st, 21'h000abc, 2);
        settle();
        chk(char_mode, pahc_pkg::MODE_DEFAULT);
        for (int j = 0; j < 4; j++) begin
            uv = 2'(j);
            head(8'h03, 6'h07, j != 3, 2'(j % 3), uv);
            body(8'h03, 21'h001000 + 21'(j * 16), 2, 1'b1);
            settle();
            chk(char_mode, uv);
            chk(split_ok, uv == 2'b00);
            chk(n_ok, ok0 + (j == 3));
        end
        chk(saw_full, 1'b1);
        stall <= 1'b0;
        $display("test fragments done");
        msg1(8'h04, 6'h00, 1'b0, 1'b0, 1'b0, ~csum(21'h0f0f0f, 1) ^ 7'h01, 21'h0f0f0f, 1);
        settle();
        chk(n_err, 1);
        apb(1'b0, `PAHC_OFF_COUNT, 32'h0);
        chk(rd, 32'h00010002);
        apb(1'b1, `PAHC_OFF_COUNT, 32'h0);
        apb(1'b0, `PAHC_OFF_COUNT, 32'h0);
        chk(rd, 32'h0);
        head(8'h04, 6'h09, 1'b0, 2'b00, 2'b10);
        body(8'h04, 21'h000333, 1, 1'b0);
        settle();
        chk(n_orph > 0, 1);
        $display("test errors done");
        msg1(8'h05, 6'h01, 1'b0, 1'b1, 1'b0, ~csum(21'h000100, 3), 21'h000100, 3);
        settle();
        msg1(8'h05, 6'h02, 1'b0, 1'b1, 1'b0, ~csum(21'h1abcde, 1), 21'h1abcde, 1);
        settle();
        apb(1'b0, `PAHC_OFF_MAIL_LEN, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `PAHC_OFF_MAIL_BASE, 32'h0);
        chk(rd, 32'h001abcde);
        for (int k = 0; k < 500 && u_part.got.size() < exp_q.size(); k++) @(posedge clk);
        chk(u_part.got.size(), exp_q.size());
        foreach (exp_q[k]) if (k < u_part.got.size()) chk(u_part.got[k], exp_q[k]);
        $display("test mail and stream done");
        give_verdict();
    end
endmodule : tb_pahc_checker
